//--- logic/bfs_supervisor.v
// Fault supervisor for a two-string boost LED backlight driver
// Functional notes
// - Switch current limit blanks boost for as long as it is asserted; sinks on, no flag.
// - Secondary overvoltage latches boost and sinks off and raises the flag.
// - Latch clears only after enable/dim held low for the full count, or on input undervoltage.
// - At startup, soft-start waits while any channel reads shorted.
// - Open channel: boost runs to overvoltage, unregulated strings are dropped.
// - Current-set overcurrent stops boost and sinks until cleared; no flag.
// - Freq/sync overcurrent stops all and flags; restart through soft-start.
// - Output overvoltage suspends switching while tripped; sinks on, no flag.
// - Channel over short threshold drops only that string.
// - Overtemperature stops all, auto-restarts after clearing; no flag.
// - Input undervoltage stops all and clears every latched fault.
// - Long enable/dim low enters shutdown and clears all fault state.
// - Each rising dim edge re-tests channels dropped for a short.
// - Fault flag is active-low open drain, released with no flagged fault.
`timescale 1ns/100ps
`default_nettype none
`include "bfs_map.vh"
module bfs_supervisor (
   // Clock and reset
   input wire clk_sys_in,
   input wire sys_rst_in,
   // Control pin
   input wire en_dim_in,
   // Comparator and detector levels
   input wire switch_current_limit_in,
   input wire secondary_overvoltage_in,
   input wire output_overvoltage_in,
   input wire current_set_overcurrent_in,
   input wire freq_sync_overcurrent_in,
   input wire overtemp_in,
   input wire input_undervoltage_in,
   input wire [`BFS_NUM_CH-1:0] channel_short_in,
   input wire [`BFS_NUM_CH-1:0] channel_in_regulation_in,
   // Power stage controls
   output reg boost_enable_out,
   output reg softstart_active_out,
   output reg raise_output_out,
   output reg [`BFS_NUM_CH-1:0] sink_enable_out,
   // Fault flag pin, open drain, low means fault
   output reg fault_flag_out_o,
   output reg fault_flag_out_oe
);
   localparam N = `BFS_NUM_CH;
   localparam SW = 8 + 2 * N;
   wire [SW-1:0] sync_w;
   wire en_s;
   wire ilim_s;
   wire ovp2_s;
   wire ovp_s;
   wire current_set_pin_s;
   wire fsync_s;
   wire otp_s;
   wire uvlo_s;
   wire [N-1:0] short_s;
   wire [N-1:0] reg_s;
   bfs_sync2 #(.W(SW)) u_sync (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .async_in({en_dim_in, switch_current_limit_in, secondary_overvoltage_in,
                 output_overvoltage_in, current_set_overcurrent_in,
                 freq_sync_overcurrent_in, overtemp_in, input_undervoltage_in,
                 channel_short_in, channel_in_regulation_in}),
      .sync_out(sync_w)
   );
   assign {en_s, ilim_s, ovp2_s, ovp_s, current_set_pin_s, fsync_s, otp_s, uvlo_s, short_s, reg_s} = sync_w;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg ovp2_latch_r;
   reg en_prev_r;
   reg [`BFS_EN_CNT_W-1:0] en_low_cnt_r;
   reg shutdown_r;
   reg [`BFS_SS_CNT_W-1:0] ss_cnt_r;
   reg open_search_r;
   reg [N-1:0] ch_open_r;
   reg [N-1:0] ch_short_r;

   wire en_rise = en_s & ~en_prev_r;
   wire en_low_full = (en_low_cnt_r == `BFS_EN_OFF_CYCLES);
   // Faults that force everything off
   wire hard_off = ovp2_latch_r | ovp2_s | current_set_pin_s | fsync_s | otp_s | uvlo_s | shutdown_r;
   wire restart_off = fsync_s | otp_s | uvlo_s | ovp2_latch_r | ovp2_s | shutdown_r;
   wire any_unreg = |(~reg_s & ~ch_short_r & ~ch_open_r);

   // Enable/dim low-time counter and shutdown
   always @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         en_prev_r <= 1'b0;
         en_low_cnt_r <= {`BFS_EN_CNT_W{1'b0}};
         shutdown_r <= 1'b1;
      end else begin
         en_prev_r <= en_s;
         if (en_s) begin
            en_low_cnt_r <= {`BFS_EN_CNT_W{1'b0}};
            shutdown_r <= 1'b0;
         end else if (!en_low_full) begin
            en_low_cnt_r <= en_low_cnt_r + 1'b1;
         end else begin
            shutdown_r <= 1'b1;
         end
      end
   end

   // Secondary overvoltage latch: set wins over clear
   always @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ovp2_latch_r <= 1'b0;
      end else if (ovp2_s) begin
         ovp2_latch_r <= 1'b1;
      end else if (uvlo_s || en_low_full) begin
         ovp2_latch_r <= 1'b0;
      end
   end

   // Startup sequencing
   always @* begin
      state_nxt = state_r;
      case (state_r)
         `BFS_ST_OFF: begin
            if (!restart_off && !current_set_pin_s)
               state_nxt = `BFS_ST_WAIT;
         end
         `BFS_ST_WAIT: begin
            if (restart_off)
               state_nxt = `BFS_ST_OFF;
            else if (~|short_s)
               state_nxt = `BFS_ST_SOFT;
         end
         `BFS_ST_SOFT: begin
            if (restart_off)
               state_nxt = `BFS_ST_OFF;
            else if (ss_cnt_r == `BFS_SOFTSTART_CYCLES)
               state_nxt = `BFS_ST_RUN;
         end
         `BFS_ST_RUN: begin
            if (restart_off)
               state_nxt = `BFS_ST_OFF;
         end
         default: state_nxt = `BFS_ST_OFF;
      endcase
   end

   always @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state_r <= `BFS_ST_OFF;
         ss_cnt_r <= {`BFS_SS_CNT_W{1'b0}};
         open_search_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == `BFS_ST_SOFT && state_nxt == `BFS_ST_SOFT)
            ss_cnt_r <= ss_cnt_r + 1'b1;
         else
            ss_cnt_r <= {`BFS_SS_CNT_W{1'b0}};
         // Open channel search: raise output until overvoltage trips
         if (state_r != `BFS_ST_RUN)
            open_search_r <= 1'b0;
         else if (ovp_s)
            open_search_r <= 1'b0;
         else if (any_unreg)
            open_search_r <= 1'b1;
      end
   end

   // Per-channel open and short removal
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_ch
         always @(posedge clk_sys_in) begin
            if (sys_rst_in) begin
               ch_open_r[g] <= 1'b0;
               ch_short_r[g] <= 1'b0;
            end else if (uvlo_s || shutdown_r || state_r != `BFS_ST_RUN) begin
               ch_open_r[g] <= 1'b0;
               ch_short_r[g] <= 1'b0;
            end else begin
               if (short_s[g])
                  ch_short_r[g] <= 1'b1;
               else if (en_rise)
                  ch_short_r[g] <= 1'b0;
               if (open_search_r && ovp_s && !reg_s[g])
                  ch_open_r[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // Registered outputs
   always @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         boost_enable_out <= 1'b0;
         softstart_active_out <= 1'b0;
         raise_output_out <= 1'b0;
         sink_enable_out <= {N{1'b0}};
         fault_flag_out_o <= 1'b0;
         fault_flag_out_oe <= 1'b0;
      end else begin
         if (hard_off || state_nxt == `BFS_ST_OFF || state_nxt == `BFS_ST_WAIT) begin
            boost_enable_out <= 1'b0;
            sink_enable_out <= {N{1'b0}};
         end else begin
            boost_enable_out <= ~ilim_s & ~ovp_s;
            sink_enable_out <= ~(ch_short_r | ch_open_r | (short_s & ~{N{en_rise}}));
         end
         softstart_active_out <= (state_nxt == `BFS_ST_SOFT) && !hard_off;
         raise_output_out <= open_search_r && !ovp_s && !hard_off;
         fault_flag_out_o <= 1'b0;
         // Flag follows the latch's next value so it drops in the same cycle the latch clears
         fault_flag_out_oe <= (ovp2_latch_r & ~uvlo_s & ~en_low_full) | ovp2_s | fsync_s;
      end
   end
endmodule // bfs_supervisor
`default_nettype wire

//--- logic/bfs_sync2.v
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module bfs_sync2 #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire sys_rst_in,
   // Data
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;
   always @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end
   assign sync_out = sync_r;
endmodule // bfs_sync2
`default_nettype wire

//--- pkg/bfs_map.vh
// Timing counts and fixed figures for the backlight fault supervisor
`ifndef BFS_MAP_VH
`define BFS_MAP_VH
// Enable/dim low time that shuts down and clears latches, in clock cycles
`define BFS_EN_OFF_CYCLES 32750
`define BFS_EN_CNT_W 15
// Soft-start ramp length in clock cycles
`define BFS_SOFTSTART_CYCLES 1024
`define BFS_SS_CNT_W 11
`define BFS_NUM_CH 2
// Supervisor states
`define BFS_ST_OFF 2'h0
`define BFS_ST_WAIT 2'h1
`define BFS_ST_SOFT 2'h2
`define BFS_ST_RUN 2'h3
`endif

//--- test/bfs_chk.sv
// Checker of output relations for the fault supervisor
`timescale 1ns/100ps
`default_nettype none
module bfs_chk (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // Comparator levels
   input wire logic switch_current_limit_in,
   input wire logic output_overvoltage_in,
   input wire logic secondary_overvoltage_in,
   input wire logic current_set_overcurrent_in,
   input wire logic freq_sync_overcurrent_in,
   input wire logic overtemp_in,
   input wire logic input_undervoltage_in,
   // Supervisor outputs
   input wire logic boost_enable_out,
   input wire logic fault_flag_out_oe,
   input wire logic [1:0] sink_enable_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   wire off = !boost_enable_out && sink_enable_out == 2'h0;
   a_ovp2_latch: assert property (
      $past(secondary_overvoltage_in, 3) |-> off && fault_flag_out_oe) else $error("ovp2");
   a_flag_cause: assert property ($rose(fault_flag_out_oe) |->
      $past(secondary_overvoltage_in, 3) || $past(freq_sync_overcurrent_in, 3)) else $error("flag");
   a_ocp_blank: assert property (
      switch_current_limit_in[*4] |-> !boost_enable_out && !fault_flag_out_oe) else $error("ocp");
   a_ovp_suspend: assert property (
      output_overvoltage_in[*4] |-> !boost_enable_out) else $error("ovp");
   a_current_set_pin_off: assert property (
      current_set_overcurrent_in[*4] |-> off && !fault_flag_out_oe) else $error("current_set_pin");
   a_fsync_off: assert property (
      freq_sync_overcurrent_in[*4] |-> off && fault_flag_out_oe) else $error("fsync");
   a_otp_off: assert property (
      overtemp_in[*4] |-> off && !fault_flag_out_oe) else $error("otp");
   a_uvlo_clear: assert property (
      input_undervoltage_in[*4] |-> off && !fault_flag_out_oe) else $error("uvlo");
endmodule // bfs_chk
bind bfs_supervisor bfs_chk u_chk (
   .clk_sys_in(clk_sys_in),
   .sys_rst_in(sys_rst_in),
   .switch_current_limit_in(switch_current_limit_in),
   .output_overvoltage_in(output_overvoltage_in),
   .secondary_overvoltage_in(secondary_overvoltage_in),
   .current_set_overcurrent_in(current_set_overcurrent_in),
   .freq_sync_overcurrent_in(freq_sync_overcurrent_in),
   .overtemp_in(overtemp_in),
   .input_undervoltage_in(input_undervoltage_in),
   .boost_enable_out(boost_enable_out),
   .fault_flag_out_oe(fault_flag_out_oe),
   .sink_enable_out(sink_enable_out)
);
`default_nettype wire

//--- test/bfs_plant.sv
// Analog side model: comparators, power stage and fault pin pull-up
`timescale 1ns/100ps
`default_nettype none
module bfs_plant (
   input wire logic clk_sys_in,
   input wire logic [6:0] fault_in,
   input wire logic [1:0] open_in,
   input wire logic [1:0] sink_en_in,
   input wire logic raise_in,
   input wire logic flag_oe_in,
   output logic [6:0] cmp_out,
   output logic [1:0] reg_out,
   output logic flag_pin_out
);
   logic raise_r;
   always_ff @(posedge clk_sys_in) raise_r <= raise_in;
   // Raising the output with an open string ends at the overvoltage trip
   assign cmp_out = fault_in | {5'h0, raise_r, 1'h0};
   // An open string never reaches regulation
   assign reg_out = sink_en_in & ~open_in;
   // Pull-up returns the pin high unless the supervisor pulls it low
   assign flag_pin_out = flag_oe_in ? 1'b0 : 1'b1;
endmodule // bfs_plant
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the fault supervisor
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk_sys_in = 0, sys_rst_in = 1, en_dim_in = 0, boost, ss, raise, fo, foe, pin;
   logic [6:0] fault = 0, cmp;
   logic [1:0] short_req = 0, open_req = 0, regs, sinks;
   int n_fail = 0, compares = 0, cyc = 0, seed = 54044, k, f;
   wire [3:0] st = {pin, boost, sinks};
   bfs_supervisor u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .en_dim_in(en_dim_in), .switch_current_limit_in(cmp[0]), .output_overvoltage_in(cmp[1]),
      .current_set_overcurrent_in(cmp[2]), .freq_sync_overcurrent_in(cmp[3]),
      .overtemp_in(cmp[4]), .input_undervoltage_in(cmp[5]), .secondary_overvoltage_in(cmp[6]),
      .channel_short_in(short_req), .channel_in_regulation_in(regs), .boost_enable_out(boost),
      .softstart_active_out(ss), .raise_output_out(raise), .sink_enable_out(sinks),
      .fault_flag_out_o(fo), .fault_flag_out_oe(foe));
   bfs_plant u_plant (.clk_sys_in(clk_sys_in), .fault_in(fault), .open_in(open_req),
      .sink_en_in(sinks), .raise_in(raise), .flag_oe_in(foe), .cmp_out(cmp), .reg_out(regs),
      .flag_pin_out(pin));
   initial forever #5 clk_sys_in = ~clk_sys_in;
   task automatic wrap_up();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic chk_bit(string s, logic e, logic v);
      compares++;
      if (v !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", s, e, v);
      end
   endtask
   task automatic chk(string s, logic [3:0] e);
      compares++;
      if (st !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", s, e, st);
      end
      chk_bit("flag data", 1'b0, fo);
      chk_bit("raise idle", 1'b0, raise);
   endtask
   task automatic wait_up(string s);
      for (k = 0; k < 3000 && (boost !== 1'b1 || ss !== 1'b0); k++) tick(1);
      // Let a re-enabled sink settle through regulation before looking
      tick(40);
      chk(s, 4'hf);
      $display("done %s", s);
   endtask
   // Expected {pin, boost, sinks} while a fault is held
   function automatic logic [3:0] exp_st(int f);
      return {f != 3, 1'b0, f < 2 ? 2'h3 : 2'h0};
   endfunction
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 95000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      tick(4);
      sys_rst_in <= 0;
      short_req <= 2'h1;
      en_dim_in <= 1;
      tick(1500);
      chk("startup hold", 4'h8);
      short_req <= 0;
      tick(20);
      chk_bit("softstart", 1'b1, ss);
      wait_up("startup");
      for (int i = 0; i < 12; i++) begin
         f = {$random(seed)} % 6;
         fault[f] <= 1;
         tick(6 + {$random(seed)} % 20);
         chk("fault", exp_st(f));
         fault <= 0;
         wait_up("fault");
      end
      short_req <= 2'h1;
      tick(10);
      chk("short drop", 4'he);
      short_req <= 0;
      en_dim_in <= 0;
      tick(10);
      en_dim_in <= 1;
      wait_up("short retest");
      fault[6] <= 1;
      tick(8);
      fault[6] <= 0;
      tick(100);
      chk("latch", 4'h0);
      en_dim_in <= 0;
      tick(32000);
      en_dim_in <= 1;
      tick(10);
      chk("early release", 4'h0);
      en_dim_in <= 0;
      tick(32760);
      chk("shutdown", 4'h8);
      en_dim_in <= 1;
      wait_up("shutdown");
      fault[6] <= 1;
      tick(8);
      fault <= 7'h20;
      tick(20);
      chk("uvlo", 4'h8);
      fault <= 0;
      wait_up("uvlo");
      open_req <= 2'h2;
      tick(6);
      chk_bit("raise", 1'b1, raise);
      tick(294);
      chk("open drop", 4'hd);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
